// ### design/output_pin_function_select.sv
// Output pin function selector: picks and times the source of one output pin.
`timescale 1ns/1ps
module output_pin_function_select #(
    parameter int unsigned MS_CYCLES = pin_func_pkg::CYC_PER_MS,
    parameter bit IS_FIRST_OUTPUT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] cfg_word1,
    input wire logic [15:0] cfg_word2,
    input wire logic [15:0] cfg_word3,
    input wire logic [15:0] cfg_word4,
    input wire logic [15:0] cfg_word5,
    input wire logic [31:0] event_status,
    input wire logic [31:0] event_latched,
    input wire logic [31:0] manual_ctrl,
    input wire logic [31:0] traj_status,
    input wire logic signed [31:0] pos_cmd,
    input wire logic signed [31:0] pos_act,
    input wire logic [8:0] phase_deg,
    input wire logic trace_we,
    input wire logic [2:0] trace_addr,
    input wire logic signed [31:0] trace_data,
    input wire logic regen_req,
    input wire logic sync0_pin,
    input wire logic hw_cmp_result,
    input wire logic brake_req,
    input wire logic sto_pin,
    input wire logic multi_sync_tick,
    output logic pin_out,
    output logic pin_active
);

    // Any bit of a register selected by a 32-bit mask.
    function automatic logic masked_any(input logic [31:0] val, input logic [31:0] mask);
        masked_any = |(val & mask);
    endfunction

    // Rising crossing: below the point before, at or above it now.
    function automatic logic cross_up(input logic signed [31:0] prev, input logic signed [31:0] cur,
                                      input logic signed [31:0] pt);
        cross_up = (prev < pt) && (cur >= pt);
    endfunction

    // Falling crossing: at or above the point before, below it now.
    function automatic logic cross_dn(input logic signed [31:0] prev, input logic signed [31:0] cur,
                                      input logic signed [31:0] pt);
        cross_dn = (prev >= pt) && (cur < pt);
    endfunction

    // Pin inputs pass two flip-flops before any logic reads them.
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic sync0_prev;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            sync0_prev <= 1'b0;
        end else begin
            pin_meta <= {sto_pin, sync0_pin};
            pin_sync <= pin_meta;
            sync0_prev <= pin_sync[0];
        end
    end

    wire sync0_rise = pin_sync[0] && !sync0_prev;
    wire sto_level = pin_sync[1];

    // Time base for millisecond holds and microsecond PWM steps.
    tick_if ticks ();

    time_base #(
        .MS_CYCLES(MS_CYCLES)
    ) u_time_base (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ticks(ticks)
    );

    // Configuration fields; bits 5-7 and 10-13 are not read here.
    wire [4:0] fn = cfg_word1[pin_func_pkg::FN_MSB:pin_func_pkg::FN_LSB];
    wire opt_a = cfg_word1[pin_func_pkg::OPT_A_BIT];
    wire opt_b = cfg_word1[pin_func_pkg::OPT_B_BIT];
    wire invert = cfg_word1[pin_func_pkg::INVERT_BIT];
    wire sync_out = cfg_word1[pin_func_pkg::SYNC_OUT_BIT];
    wire [31:0] mask = {cfg_word3, cfg_word2};
    wire signed [31:0] pos_lo = {cfg_word3, cfg_word2};
    wire signed [31:0] pos_hi = {cfg_word5, cfg_word4};
    wire [31:0] hold_ms = {cfg_word5, cfg_word4};

    // Register tracking: active when any selected bit is set.
    wire trk_event = masked_any(event_status, mask);
    wire trk_latched = masked_any(event_latched, mask);
    wire trk_manual = masked_any(manual_ctrl, mask);
    wire trk_traj = masked_any(traj_status, mask);

    // Position source for window and crossing compares.
    wire signed [31:0] pos_sel = opt_a ? pos_cmd : pos_act;
    logic signed [31:0] pos_prev;
    logic prev_valid;

    // The previous sample is only trusted after one full cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_prev <= 32'sh0000_0000;
            prev_valid <= 1'b0;
        end else begin
            pos_prev <= pos_sel;
            prev_valid <= 1'b1;
        end
    end

    // Window compare, both limits inclusive.
    wire in_window = (pos_sel >= pos_lo) && (pos_sel <= pos_hi);

    // Crossing detection of the single compare point.
    wire hit_up = prev_valid && cross_up(pos_prev, pos_sel, pos_lo);
    wire hit_dn = prev_valid && cross_dn(pos_prev, pos_sel, pos_lo);
    wire cross_trig = ((fn == pin_func_pkg::FN_CROSS_UP) && hit_up)
                    || ((fn == pin_func_pkg::FN_CROSS_DN) && hit_dn)
                    || ((fn == pin_func_pkg::FN_CROSS_ANY) && (hit_up || hit_dn));

    // Millisecond hold after a crossing; a new crossing restarts it.
    logic [31:0] hold_cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= 32'h0000_0000;
        end else if (cross_trig) begin
            hold_cnt <= hold_ms;
        end else if (ticks.ms_tick && hold_cnt != 32'h0000_0000) begin
            hold_cnt <= hold_cnt - 32'h0000_0001;
        end
    end

    // A hold count of zero never raises the pin; the first tick may come early.
    wire hold_active = (hold_cnt != 32'h0000_0000);

    // Phase window: fold the offset into one turn, then test the half turn.
    wire signed [15:0] off_raw = cfg_word2;
    wire signed [15:0] off_mod = off_raw % 16'sh0168;
    wire signed [11:0] ph_sum = $signed({3'h0, phase_deg}) + 12'(off_mod);
    wire signed [11:0] ph_lo = (ph_sum < 12'sh000) ? ph_sum + pin_func_pkg::DEG_FULL : ph_sum;
    wire signed [11:0] ph_norm = (ph_lo >= pin_func_pkg::DEG_FULL) ? ph_lo - pin_func_pkg::DEG_FULL : ph_lo;
    wire phase_on = (ph_norm >= 12'sh000) && (ph_norm < pin_func_pkg::DEG_HALF);

    // Trace position list, written by the capture logic one word at a time.
    logic signed [31:0] trace_pos [pin_func_pkg::TRACE_DEPTH];
    logic trace_hit;

    always_ff @(posedge clk_sys) begin
        if (trace_we) begin
            trace_pos[trace_addr] <= trace_data;
        end
    end

    // Every stored point is checked each cycle, in either direction.
    always_comb begin
        trace_hit = 1'b0;
        for (int i = 0; i < pin_func_pkg::TRACE_DEPTH; i++) begin
            if (prev_valid && (cross_up(pos_prev, pos_sel, trace_pos[i])
                || cross_dn(pos_prev, pos_sel, trace_pos[i]))) begin
                trace_hit = 1'b1;
            end
        end
    end

    // Fixed-width pulse for trace hits and SYNC0 events.
    wire pulse_trig = ((fn == pin_func_pkg::FN_TRACE) && trace_hit)
                    || ((fn == pin_func_pkg::FN_SYNC0) && sync0_rise);
    logic [15:0] pulse_cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= 16'h0000;
        end else if (pulse_trig) begin
            pulse_cnt <= pin_func_pkg::PULSE_CYC;
        end else if (pulse_cnt != 16'h0000) begin
            pulse_cnt <= pulse_cnt - 16'h0001;
        end
    end

    wire pulse_active = (pulse_cnt != 16'h0000);

    // Brake sequencer: full on for the delay, then PWM in microsecond steps.
    pin_func_pkg::brake_state_e br_state;
    pin_func_pkg::brake_state_e next_br_state;
    logic [15:0] br_delay;
    logic [15:0] pwm_us;
    wire [15:0] pwm_on_us = cfg_word2;
    wire [15:0] pwm_per_us = cfg_word3;
    wire [15:0] delay_ms = cfg_word5;
    wire brake_run = brake_req && (fn == pin_func_pkg::FN_BRAKE);
    wire delay_done = (br_delay >= delay_ms);
    wire pwm_wrap = (pwm_us + 16'h0001 >= pwm_per_us);

    // Next state of the brake sequence; dropping the request always wins.
    always_comb begin
        next_br_state = br_state;
        case (br_state)
            pin_func_pkg::BR_IDLE: begin
                if (brake_run) begin
                    next_br_state = pin_func_pkg::BR_FULL;
                end
            end
            pin_func_pkg::BR_FULL: begin
                if (!brake_run) begin
                    next_br_state = pin_func_pkg::BR_IDLE;
                end else if (delay_done) begin
                    next_br_state = pin_func_pkg::BR_PWM;
                end
            end
            pin_func_pkg::BR_PWM: begin
                if (!brake_run) begin
                    next_br_state = pin_func_pkg::BR_IDLE;
                end
            end
            default: begin
                next_br_state = pin_func_pkg::BR_IDLE;
            end
        endcase
    end

    // Delay counts milliseconds in the full-on phase; PWM counts microseconds.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            br_state <= pin_func_pkg::BR_IDLE;
            br_delay <= 16'h0000;
            pwm_us <= 16'h0000;
        end else begin
            br_state <= next_br_state;
            if (br_state != pin_func_pkg::BR_FULL) begin
                br_delay <= 16'h0000;
            end else if (ticks.ms_tick && !delay_done) begin
                br_delay <= br_delay + 16'h0001;
            end
            if (br_state != pin_func_pkg::BR_PWM) begin
                pwm_us <= 16'h0000;
            end else if (ticks.us_tick) begin
                pwm_us <= pwm_wrap ? 16'h0000 : pwm_us + 16'h0001;
            end
        end
    end

    // An on time at or above the period leaves the brake fully on.
    wire brake_on = (br_state == pin_func_pkg::BR_FULL)
                  || ((br_state == pin_func_pkg::BR_PWM) && (pwm_us < pwm_on_us));

    // Combined event and manual mode; the event test takes precedence.
    wire comb_out = trk_event ? !opt_a
                  : trk_manual ? !opt_b
                  : opt_b;

    // Source selection; unknown codes fall to the inactive level.
    wire sel_active =
        (fn == pin_func_pkg::FN_EVENT) ? trk_event :
        (fn == pin_func_pkg::FN_LATCHED) ? trk_latched :
        (fn == pin_func_pkg::FN_MANUAL) ? trk_manual :
        (fn == pin_func_pkg::FN_TRAJ) ? trk_traj :
        (fn == pin_func_pkg::FN_WINDOW) ? in_window :
        (fn == pin_func_pkg::FN_CROSS_UP) ? hold_active :
        (fn == pin_func_pkg::FN_CROSS_DN) ? hold_active :
        (fn == pin_func_pkg::FN_CROSS_ANY) ? hold_active :
        (fn == pin_func_pkg::FN_PHASE) ? phase_on :
        (fn == pin_func_pkg::FN_TRACE) ? pulse_active :
        (fn == pin_func_pkg::FN_REGEN) ? regen_req :
        (fn == pin_func_pkg::FN_SYNC0) ? pulse_active :
        (fn == pin_func_pkg::FN_HW_CMP) ? hw_cmp_result :
        (fn == pin_func_pkg::FN_EV_MAN) ? comb_out :
        (fn == pin_func_pkg::FN_BRAKE) ? brake_on :
        (fn == pin_func_pkg::FN_STO) ? sto_level :
        1'b0;

    // Only the first output can act as multi-drive sync output.
    wire sync_mode = IS_FIRST_OUTPUT && sync_out;
    wire next_active = sync_mode ? multi_sync_tick : sel_active;
    wire next_pin = next_active ^ invert;

    // Registered every cycle so each source reaches the pin one cycle later.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_active <= 1'b0;
            pin_out <= pin_func_pkg::PIN_RST;
        end else begin
            pin_active <= next_active;
            pin_out <= next_pin;
        end
    end

endmodule // output_pin_function_select

// ### design/time_base.sv
// Divider that produces one-cycle microsecond and millisecond ticks.
`timescale 1ns/1ps
module time_base #(
    parameter int unsigned MS_CYCLES = pin_func_pkg::CYC_PER_MS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    tick_if.src ticks
);
    logic [31:0] us_cnt;
    logic [31:0] ms_cnt;
    wire us_end = (us_cnt == 32'(pin_func_pkg::CYC_PER_US - 1));
    wire ms_end = (ms_cnt == 32'(MS_CYCLES - 1));

    // Free-running dividers; both restart at their terminal count.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            us_cnt <= 32'h0000_0000;
            ms_cnt <= 32'h0000_0000;
            ticks.us_tick <= 1'b0;
            ticks.ms_tick <= 1'b0;
        end else begin
            us_cnt <= us_end ? 32'h0000_0000 : us_cnt + 32'h0000_0001;
            ms_cnt <= ms_end ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
            ticks.us_tick <= us_end;
            ticks.ms_tick <= ms_end;
        end
    end
endmodule // time_base

// ### inc/pin_func_pkg.sv
// Constants, codes and types for the output pin function selector.
// Contract
// - Code 0 follows masked live event status.
// - Code 1 follows masked latched event status.
// - Code 2 follows masked manual output control.
// - Code 3 follows masked trajectory status.
// - Bits 0-4 select; code 4 window compare.
// - Bit 14 picks commanded, else actual position.
// - Code 5 rising crossing, hold for milliseconds.
// - Code 6 falling crossing, same hold.
// - Code 7 crossing either way, same hold.
// - Code 8 phase plus offset below 180.
// - Code 9 pulses on trace array crossings.
// - Code 10 drives regeneration resistor switch.
// - Code 11 pulses on each SYNC0 event.
// - Code 16 follows hardware position compare result.
// - Code 17 merges events and manual bit.
// - Code 17 events first, bit 14 polarity.
// - Code 17 manual next, bit 15 polarity.
// - Code 17 otherwise active when bit 15.
// - Brake: full on, then timed PWM.
// - Brake words: on, period, reserved, delay.
// - Safe torque off indication while STO disables.
// - Tracking active when any masked bit set.
// - Bit 8 inverts pin polarity.
// - Bit 9 makes first output sync output.
package pin_func_pkg;

    // Function codes held in bits 0-4 of the first word.
    localparam logic [4:0] FN_EVENT = 5'h00;
    localparam logic [4:0] FN_LATCHED = 5'h01;
    localparam logic [4:0] FN_MANUAL = 5'h02;
    localparam logic [4:0] FN_TRAJ = 5'h03;
    localparam logic [4:0] FN_WINDOW = 5'h04;
    localparam logic [4:0] FN_CROSS_UP = 5'h05;
    localparam logic [4:0] FN_CROSS_DN = 5'h06;
    localparam logic [4:0] FN_CROSS_ANY = 5'h07;
    localparam logic [4:0] FN_PHASE = 5'h08;
    localparam logic [4:0] FN_TRACE = 5'h09;
    localparam logic [4:0] FN_REGEN = 5'h0A;
    localparam logic [4:0] FN_SYNC0 = 5'h0B;
    localparam logic [4:0] FN_HW_CMP = 5'h10;
    localparam logic [4:0] FN_EV_MAN = 5'h11;
    localparam logic [4:0] FN_BRAKE = 5'h12;
    localparam logic [4:0] FN_STO = 5'h13;

    // Field positions in the first configuration word.
    localparam int FN_LSB = 0;
    localparam int FN_MSB = 4;
    localparam int INVERT_BIT = 8;
    localparam int SYNC_OUT_BIT = 9;
    localparam int OPT_A_BIT = 14;
    localparam int OPT_B_BIT = 15;

    // Timing: figures in their own unit, cycle counts derived.
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS = 1000;
    localparam int MS_NS = 1000000;
    localparam int PULSE_US = 1;
    localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] PULSE_CYC = 16'(PULSE_US * CYC_PER_US);

    // Phase angle figures in degrees.
    localparam logic signed [11:0] DEG_HALF = 12'sh0B4;
    localparam logic signed [11:0] DEG_FULL = 12'sh168;

    // Trace memory size and reset level of the pin.
    localparam int TRACE_DEPTH = 8;
    localparam int TRACE_AW = 3;
    localparam logic PIN_RST = 1'b0;

    // Brake sequencer states.
    typedef enum logic [1:0] {
        BR_IDLE = 2'b00,
        BR_FULL = 2'b01,
        BR_PWM = 2'b10
    } brake_state_e;

endpackage

// ### inc/tick_if.sv
// Interface carrying the microsecond and millisecond ticks.
`timescale 1ns/1ps
interface tick_if;
    logic us_tick;
    logic ms_tick;
    modport src (output us_tick, output ms_tick);
    modport snk (input us_tick, input ms_tick);
endinterface // tick_if

// ### verification/pin_func_props.sv
// Checker for the same-clock sources other than the phase window, and polarity, of the output pin selector.
`timescale 1ns/1ps
module pin_func_props #(
    parameter int unsigned MS_CYCLES = 250,
    parameter bit IS_FIRST_OUTPUT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] cfg_word1,
    input wire logic [15:0] cfg_word2,
    input wire logic [15:0] cfg_word3,
    input wire logic [15:0] cfg_word4,
    input wire logic [15:0] cfg_word5,
    input wire logic [31:0] event_status,
    input wire logic [31:0] event_latched,
    input wire logic [31:0] manual_ctrl,
    input wire logic [31:0] traj_status,
    input wire logic signed [31:0] pos_cmd,
    input wire logic signed [31:0] pos_act,
    input wire logic regen_req,
    input wire logic hw_cmp_result,
    input wire logic pin_out,
    input wire logic pin_active
);
    // Decoded view of the configuration; the sync override masks every function.
    wire [4:0] fn = cfg_word1[4:0];
    wire plain = !(IS_FIRST_OUTPUT && cfg_word1[9]);
    wire [31:0] lo = {cfg_word3, cfg_word2};
    wire signed [31:0] pos = cfg_word1[14] ? pos_cmd : pos_act;
    wire in_win = $signed(lo) <= pos && pos <= $signed({cfg_word5, cfg_word4});
    wire ev = |(event_status & lo);
    wire man = |(manual_ctrl & lo);
    wire mix = ev ? !cfg_word1[14] : (man ? !cfg_word1[15] : cfg_word1[15]);
    wire undef = (fn > 5'h0B && fn < 5'h10) || fn > 5'h13;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_pin_polarity: assert property ($past(rst_n) && $past(plain) |-> pin_out == (pin_active ^ $past(cfg_word1[8])))
        else $error("pin level does not match invert setting");
    a_event_track: assert property (plain && fn == 5'h00 |=> pin_active == $past(ev))
        else $error("event tracking wrong");
    a_latched_track: assert property (plain && fn == 5'h01 |=> pin_active == $past(|(event_latched & lo)))
        else $error("latched tracking wrong");
    a_manual_track: assert property (plain && fn == 5'h02 |=> pin_active == $past(man))
        else $error("manual tracking wrong");
    a_traj_track: assert property (plain && fn == 5'h03 |=> pin_active == $past(|(traj_status & lo)))
        else $error("trajectory tracking wrong");
    a_window_cmp: assert property (plain && fn == 5'h04 |=> pin_active == $past(in_win))
        else $error("window compare wrong");
    a_mixed_mode: assert property (plain && fn == 5'h11 |=> pin_active == $past(mix))
        else $error("combined event and manual mode wrong");
    a_regen_follow: assert property (plain && fn == 5'h0A |=> pin_active == $past(regen_req))
        else $error("regen switch wrong");
    a_hw_cmp: assert property (plain && fn == 5'h10 |=> pin_active == $past(hw_cmp_result))
        else $error("hardware compare tracking wrong");
    a_undef_quiet: assert property (plain && undef |=> !pin_active)
        else $error("undefined code drove pin active");
endmodule // pin_func_props

bind output_pin_function_select pin_func_props #(.MS_CYCLES(MS_CYCLES), .IS_FIRST_OUTPUT(IS_FIRST_OUTPUT)) u_pin_func_props (
    .clk_sys, .rst_n, .cfg_word1, .cfg_word2, .cfg_word3, .cfg_word4, .cfg_word5, .event_status,
    .event_latched, .manual_ctrl, .traj_status, .pos_cmd, .pos_act, .regen_req, .hw_cmp_result,
    .pin_out, .pin_active);

// ### verification/pin_load.sv
// Model of the equipment wired to the output pin and to the drive's async inputs.
`timescale 1ns/1ps
module pin_load (
    input wire logic pin_out,
    input wire logic sto_cmd,
    input wire logic sync_cmd,
    output wire logic sto_pin,
    output wire logic sync0_pin,
    output int pulses
);
    // Async lines move off the clock grid, so the drive's synchronisers are exercised.
    assign #3 sto_pin = sto_cmd;
    assign #3 sync0_pin = sync_cmd;
    // Counting rising edges lets the bench see each pulse the load would react to.
    initial pulses = 0;
    always @(posedge pin_out) pulses++;
endmodule // pin_load

// ### verification/test_output_pin_function_select.sv
// Self-checking bench for the output pin function selector.
`timescale 1ns/1ps
module test_output_pin_function_select;
    localparam int unsigned MSC = 250;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] w1, w2, w3, w4, w5;
    logic [31:0] es, el, mc, ts;
    logic signed [31:0] pc, pa, td;
    logic [8:0] ph;
    logic [2:0] ta;
    logic twe, rg, hc, br, mst, sto_cmd, sync_cmd, sto_pin, sync0_pin, pin_out, pin_active;
    logic [4:0] codes [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h0A, 5'h10, 5'h11, 5'h11,
                               5'h0C, 5'h0F, 5'h14, 5'h15, 5'h1F};
    int pulses, err_count, total_checks, hi_n, lo_v, hi_v, p0;

    output_pin_function_select #(.MS_CYCLES(MSC)) u_output_pin_function_select (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_word1(w1), .cfg_word2(w2), .cfg_word3(w3),
        .cfg_word4(w4), .cfg_word5(w5), .event_status(es), .event_latched(el), .manual_ctrl(mc),
        .traj_status(ts), .pos_cmd(pc), .pos_act(pa), .phase_deg(ph), .trace_we(twe),
        .trace_addr(ta), .trace_data(td), .regen_req(rg), .sync0_pin(sync0_pin),
        .hw_cmp_result(hc), .brake_req(br), .sto_pin(sto_pin), .multi_sync_tick(mst),
        .pin_out(pin_out), .pin_active(pin_active));
    pin_load u_pin_load (.pin_out(pin_out), .sto_cmd(sto_cmd), .sync_cmd(sync_cmd),
        .sto_pin(sto_pin), .sync0_pin(sync0_pin), .pulses(pulses));

    // Free-running system clock.
    initial forever #4 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Counts cycles with the pin active; a window covers whole pulses or PWM periods.
    task automatic count_high(input int cyc, input int exp);
        hi_n = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            #1 hi_n += int'(pin_active);
        end
        chk(hi_n, exp);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected logical pin state for the level functions, from the current inputs.
    function automatic logic exp_fn();
        logic [31:0] m;
        logic signed [31:0] p;
        int a;
        m = {w3, w2};
        p = w1[14] ? pc : pa;
        a = ((int'(ph) + int'($signed(w2))) % 360 + 360) % 360;
        case (w1[4:0])
            5'h00: return |(es & m);
            5'h01: return |(el & m);
            5'h02: return |(mc & m);
            5'h03: return |(ts & m);
            5'h04: return $signed(m) <= p && p <= $signed({w5, w4});
            5'h08: return a < 180;
            5'h0A: return rg;
            5'h10: return hc;
            5'h11: return |(es & m) ? !w1[14] : (|(mc & m) ? !w1[15] : w1[15]);
            default: return 1'b0;
        endcase
    endfunction

    // Hang guard: the whole sequence needs just over 9000 cycles, under a third of the 30000-cycle limit.
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        print_verdict();
    end

    initial begin
        {w1, w2, w3, w4, w5, es, el, mc, ts, pc, pa, td, ph, ta} = '0;
        {twe, rg, hc, br, mst, sto_cmd, sync_cmd} = '0;
        p0 = $urandom(67667);
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Random level functions with small windows so the limits are hit often.
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            lo_v = int'($urandom_range(16)) - 8;
            hi_v = int'($urandom_range(16)) - 8;
            w1 <= {2'($urandom), 5'h00, 1'($urandom), 3'($urandom), codes[$urandom_range(14)]};
            {w3, w2} <= lo_v;
            {w5, w4} <= hi_v;
            {es, el} <= {$urandom, $urandom};
            {mc, ts} <= {$urandom, $urandom};
            pc <= int'($urandom_range(16)) - 8;
            pa <= int'($urandom_range(16)) - 8;
            ph <= 9'($urandom_range(359));
            {rg, hc} <= 2'($urandom);
            @(posedge clk_sys);
            #1 chk(pin_active, exp_fn());
            chk(pin_out, exp_fn() ^ w1[8]);
        end
        // Sync output on the first output follows the multi-drive tick.
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            w1 <= 16'h0200;
            mst <= 1'($urandom);
            @(posedge clk_sys);
            #1 chk(pin_out, mst);
        end
        // Crossings: bit 0 of d picks the source, bit 1 the direction; the other source stays where it is.
        for (int c = 5; c <= 7; c++) begin
            for (int d = 0; d < 4; d++) begin
                @(posedge clk_sys);
                {w1, mc, mst} <= {16'h0002, 32'h0, 1'b0};
                {w3, w2, w5, w4} <= {32'sd100, 32'sd2};
                {pc, pa} <= d[1] ? {32'sd50, 32'sd50} : {32'sd150, 32'sd150};
                repeat (3) @(posedge clk_sys);
                w1 <= {1'b0, d[0], 9'h000, 5'(c)};
                repeat (3) @(posedge clk_sys);
                pc <= (d[0] ~^ d[1]) ? 32'sd150 : 32'sd50;
                pa <= (d[0] ^ d[1]) ? 32'sd150 : 32'sd50;
                repeat (3) @(posedge clk_sys);
                #1 chk(pin_active, (c == 5 && d[1]) || (c == 6 && !d[1]) || c == 7);
                repeat (200) @(posedge clk_sys);
                #1 chk(pin_active, (c == 5 && d[1]) || (c == 6 && !d[1]) || c == 7);
                repeat (320) @(posedge clk_sys);
                #1 chk(pin_active, 1'b0);
            end
        end
        // Trace list pulse: only the entry at 1000 lies between the two positions.
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            {twe, ta, td} <= {1'b1, 3'(i), 32'(1000 + 200 * i)};
        end
        @(posedge clk_sys);
        {twe, w1, pa} <= {1'b0, 16'h0009, 32'sd950};
        repeat (4) @(posedge clk_sys);
        pa <= 32'sd1050;
        p0 = pulses;
        count_high(300, 125);
        chk(pulses - p0, 1);
        // Fieldbus sync pulse arrives through the load's asynchronous line.
        @(posedge clk_sys);
        {w1, sync_cmd} <= {16'h000B, 1'b1};
        p0 = pulses;
        count_high(300, 125);
        chk(pulses - p0, 1);
        // Brake: at least one full millisecond on, then 2 us of every 4 us period.
        @(posedge clk_sys);
        {w1, w2, w3, w4, w5, br, sync_cmd} <= {16'h0012, 16'h0002, 16'h0004, 16'hFFFF, 16'h0002, 1'b1, 1'b0};
        repeat (2) @(posedge clk_sys);
        count_high(240, 240);
        repeat (300) @(posedge clk_sys);
        count_high(1000, 500);
        @(posedge clk_sys);
        br <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk(pin_active, 1'b0);
        // Safe torque off indication follows the synchronised input.
        @(posedge clk_sys);
        {w1, sto_cmd} <= {16'h0013, 1'b1};
        repeat (6) @(posedge clk_sys);
        #1 chk(pin_active, 1'b1);
        @(posedge clk_sys);
        sto_cmd <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 chk(pin_active, 1'b0);
        print_verdict();
    end
endmodule // test_output_pin_function_select
